//--- hdl/cgc_clk_div.sv
`timescale 1ns/1ns
`default_nettype none

module cgc_clk_div #(
	parameter int         SEL_W   = 3,
	parameter int         MAX_SEL = 4,
	parameter logic [2:0] RST_SEL = 3'h1
) (
	// clock and reset
	input  wire logic             ref_clk,
	input  wire logic             sys_rst,
	// division select, log2 of the ratio
	input  wire logic [SEL_W-1:0] sel_req,
	// divided clock as one pulse per period
	output logic                  tick,
	output logic [SEL_W-1:0]      sel_active
);

	localparam int CNT_W = MAX_SEL;

	initial begin
		if (MAX_SEL < 1 || SEL_W < 3)
			$error("cgc_clk_div: unsupported parameters");
	end

	logic [SEL_W-1:0] sel_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	wire  [CNT_W-1:0] last_cnt = ~({CNT_W{1'b1}} << sel_q);
	wire              wrap     = (cnt_q == last_cnt);

	// the tick is the last count of every ratio, so swapping at the wrap
	// never cuts a period short
	assign cnt_d      = wrap ? '0 : cnt_q + 1'b1;
	assign tick       = wrap;
	assign sel_active = sel_q;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
			sel_q <= SEL_W'(RST_SEL);
		end else begin
			cnt_q <= cnt_d;
			if (wrap)
				sel_q <= sel_req;
		end
	end

endmodule // cgc_clk_div

`default_nettype wire

//--- hdl/cgc_clock_gen.sv
// Notes on behaviour
// - low-speed oscillator runs right after every reset release
// - low-speed stop write works only when the option permits it
// - low-speed clock never drives the cpu; only watchdog and timer h1
// - pll multiplies by 8 or 12 per select bit; halt bit stops it
// - pin mode bits 7:6: 00/10 ports, 01 resonator, 11 external clock
// - reset clears pin mode register: ports, low gain
// - gain bit 0: low up to 10 MHz, high above; software sets it
// - gain bit takes one change per reset; later writes ignored
// - gain going to 1 holds the cpu clock at least 5 us
// - stop exit with high gain: 5 us hold, or oscillator wait on resonator
// - divider codes 000..100 give main clock /1../16; others prohibited
// - reset loads divider register with 01: main clock divided by two
// - shortest instruction takes two cpu clock periods
// - internal mode bit 1: 0 oscillates, 1 stops low-speed oscillator
// - main oscillator bit 7 set halts resonator or blocks external clock
`timescale 1ns/1ns
`default_nettype none

module cgc_clock_gen #(
	parameter int HOLD_CYC = cgc_pkg::CGC_HOLD_CYC
) (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	// memory access port
	input  wire cgc_pkg::cgc_bus_req_s bus_req,
	output logic [7:0]                bus_rdata,
	// option and system status
	input  wire logic                 ls_stop_allowed,
	input  wire logic                 hs_int_osc_stable,
	input  wire logic                 stop_mode,
	input  wire logic                 cpu_on_resonator,
	input  wire logic                 osc_stable_done,
	input  wire logic                 timer_h1_ls_sel,
	// pll control bits
	input  wire logic                 pll_multiplier_sel,
	input  wire logic                 pll_halt,
	// oscillator and pin controls
	output logic                      lowspeed_osc_run,
	output logic                      wdt_lowspeed_en,
	output logic                      timer_h1_lowspeed_en,
	output cgc_pkg::cgc_pin_mode_s    pin_mode,
	output logic                      high_freq_gain,
	output logic                      hs_clock_halt,
	output logic                      hs_osc_enable,
	output logic                      pll_run,
	output logic [3:0]                pll_factor,
	// cpu clock
	output logic                      cpu_clk_tick,
	output logic                      cpu_clk_hold,
	output logic [5:0]                min_instr_ref_cycles
);
	import cgc_pkg::*;

	localparam int HOLD_W = $clog2(HOLD_CYC + 1);

	initial begin
		if (HOLD_CYC < 1)
			$error("cgc_clock_gen: HOLD_CYC must be at least one");
	end

	// register state
	logic             ext_clock_select_q;
	logic             osc_pin_select_q;
	logic             gain_q;
	logic             gain_locked_q;
	logic [2:0]       div_sel_q;
	logic             ls_halt_q;
	logic             mo_halt_q;
	logic [7:0]       rdata_q;
	logic             stop_mode_q;
	cgc_hold_e        state_q;
	cgc_hold_e        state_d;
	logic [HOLD_W-1:0] hold_cnt_q;
	logic [HOLD_W-1:0] hold_cnt_d;

	// address decode
	wire hit_pm  = (bus_req.addr == CGC_ADDR_PIN_MODE);
	wire hit_div = (bus_req.addr == CGC_ADDR_CPU_DIV);
	wire hit_om  = (bus_req.addr == CGC_ADDR_OSC_MODE);
	wire hit_mo  = (bus_req.addr == CGC_ADDR_MAIN_OSC);
	wire wr_pm   = bus_req.wr & hit_pm;
	wire wr_div  = bus_req.wr & hit_div;
	wire wr_om   = bus_req.wr & hit_om;
	wire wr_mo   = bus_req.wr & hit_mo;

	// write data fields
	wire w_ext   = bus_req.wdata[CGC_PM_EXT_BIT];
	wire w_sel   = bus_req.wdata[CGC_PM_SEL_BIT];
	wire w_gain  = bus_req.wdata[CGC_PM_GAIN_BIT];
	wire [2:0] w_div = bus_req.wdata[CGC_DIV_W-1:0];
	wire w_lshalt = bus_req.wdata[CGC_OM_LSHALT_BIT];
	wire w_mohalt = bus_req.wdata[CGC_MO_HALT_BIT];

	// pin mode changes are honoured only with the high-speed clock halted,
	// so the pins never switch under a live oscillator
	wire pin_wr_ok = wr_pm & mo_halt_q;
	// one change of the gain bit per reset, after which it is frozen
	wire gain_chg  = wr_pm & ~gain_locked_q & (w_gain != gain_q);
	wire gain_rise = gain_chg & w_gain;
	// prohibited divider codes are dropped and the old ratio stays
	wire div_wr_ok = wr_div & (w_div <= CGC_DIV_CODE_MAX);
	// without the option, the stop request is not stored at all
	wire ls_wr_val = w_lshalt & ls_stop_allowed;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ext_clock_select_q <= CGC_RST_PIN_MODE[CGC_PM_EXT_BIT];
			osc_pin_select_q   <= CGC_RST_PIN_MODE[CGC_PM_SEL_BIT];
			gain_q             <= CGC_RST_PIN_MODE[CGC_PM_GAIN_BIT];
			gain_locked_q      <= 1'b0;
		end else begin
			if (pin_wr_ok) begin
				ext_clock_select_q <= w_ext;
				osc_pin_select_q   <= w_sel;
			end
			if (gain_chg) begin
				gain_q        <= w_gain;
				gain_locked_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_sel_q <= CGC_RST_CPU_DIV[CGC_DIV_W-1:0];
			ls_halt_q <= CGC_RST_OSC_MODE[CGC_OM_LSHALT_BIT];
			mo_halt_q <= CGC_RST_MAIN_OSC[CGC_MO_HALT_BIT];
		end else begin
			if (div_wr_ok)
				div_sel_q <= w_div;
			if (wr_om)
				ls_halt_q <= ls_wr_val;
			if (wr_mo)
				mo_halt_q <= w_mohalt;
		end
	end

	// read path; unmapped addresses and reserved bits read zero
	wire [7:0] rd_pm  = {ext_clock_select_q, osc_pin_select_q, 5'h00, gain_q};
	wire [7:0] rd_div = {5'h00, div_sel_q};
	wire [7:0] rd_om  = {hs_int_osc_stable, 5'h00, ls_halt_q, 1'b0};
	wire [7:0] rd_mo  = {mo_halt_q, 7'h00};
	wire [7:0] rd_mux = hit_pm  ? rd_pm  :
	                    hit_div ? rd_div :
	                    hit_om  ? rd_om  :
	                    hit_mo  ? rd_mo  : 8'h00;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst)
			rdata_q <= 8'h00;
		else if (bus_req.rd)
			rdata_q <= rd_mux;
	end

	assign bus_rdata = rdata_q;

	// low-speed oscillator and its only consumers
	assign lowspeed_osc_run     = ~ls_halt_q;
	assign wdt_lowspeed_en      = lowspeed_osc_run;
	assign timer_h1_lowspeed_en = lowspeed_osc_run & timer_h1_ls_sel;

	// pin operation mode
	wire pm_res = ~ext_clock_select_q & osc_pin_select_q;
	wire pm_ext = ext_clock_select_q & osc_pin_select_q;
	assign pin_mode.x1_port    = ~pm_res;
	assign pin_mode.x2_port    = ~osc_pin_select_q;
	assign pin_mode.resonator  = pm_res;
	assign pin_mode.ext_clk_in = pm_ext;
	assign high_freq_gain      = gain_q;
	assign hs_clock_halt       = mo_halt_q;
	// the stop instruction also shuts the high-speed source down
	assign hs_osc_enable = osc_pin_select_q & ~mo_halt_q & ~stop_mode;

	// pll
	assign pll_run    = ~pll_halt;
	assign pll_factor = pll_multiplier_sel ? CGC_PLL_FACTOR_HI
	                                       : CGC_PLL_FACTOR_LO;

	// cpu clock hold sequencer, counted on ref_clk which never stops
	// during a hold, unlike the cpu clock being held
	wire stop_exit = stop_mode_q & ~stop_mode;
	wire hold_done = (hold_cnt_q == HOLD_W'(1));

	always_comb begin
		state_d    = state_q;
		hold_cnt_d = hold_cnt_q;
		unique case (state_q)
			CGC_RUN: begin
				if (gain_rise) begin
					state_d    = CGC_HOLD;
					hold_cnt_d = HOLD_W'(HOLD_CYC);
				end else if (stop_exit & gain_q) begin
					if (cpu_on_resonator) begin
						state_d = CGC_OSC_WAIT;
					end else begin
						state_d    = CGC_HOLD;
						hold_cnt_d = HOLD_W'(HOLD_CYC);
					end
				end
			end
			CGC_HOLD: begin
				hold_cnt_d = hold_cnt_q - 1'b1;
				if (hold_done)
					state_d = CGC_RUN;
			end
			CGC_OSC_WAIT: begin
				if (osc_stable_done)
					state_d = CGC_RUN;
			end
			default: begin
				state_d = CGC_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q     <= CGC_RUN;
			hold_cnt_q  <= '0;
			stop_mode_q <= 1'b0;
		end else begin
			state_q     <= state_d;
			hold_cnt_q  <= hold_cnt_d;
			stop_mode_q <= stop_mode;
		end
	end

	// cpu clock divider, fed from the main system clock only
	logic       div_tick;
	logic [2:0] div_active;

	cgc_clk_div #(
		.SEL_W   (CGC_DIV_W),
		.MAX_SEL (int'(CGC_DIV_CODE_MAX)),
		.RST_SEL (CGC_RST_CPU_DIV[2:0])
	) u_div (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.sel_req    (div_sel_q),
		.tick       (div_tick),
		.sel_active (div_active)
	);

	// the exit edge itself is held as well: the sequencer leaves run one
	// edge later, and a divider wrap on that edge would slip a tick through
	assign cpu_clk_hold = (state_q != CGC_RUN) | stop_mode |
	                      (stop_exit & gain_q);
	assign cpu_clk_tick = div_tick & ~cpu_clk_hold;

	// two cpu periods expressed in main clock cycles
	assign min_instr_ref_cycles =
		6'(CGC_MIN_INSTR_CPU_CYC) << div_active;

endmodule // cgc_clock_gen

`default_nettype wire

//--- hdl/cgc_pkg.sv
package cgc_pkg;

	// register byte addresses
	localparam logic [15:0] CGC_ADDR_PIN_MODE = 16'hFF9F;
	localparam logic [15:0] CGC_ADDR_CPU_DIV  = 16'hFFFB;
	localparam logic [15:0] CGC_ADDR_OSC_MODE = 16'hFFA0;
	localparam logic [15:0] CGC_ADDR_MAIN_OSC = 16'hFFA2;

	// reset values
	localparam logic [7:0] CGC_RST_PIN_MODE = 8'h00;
	localparam logic [7:0] CGC_RST_CPU_DIV  = 8'h01;
	localparam logic [7:0] CGC_RST_OSC_MODE = 8'h00;
	localparam logic [7:0] CGC_RST_MAIN_OSC = 8'h80;

	// field positions
	localparam int CGC_PM_EXT_BIT    = 7;
	localparam int CGC_PM_SEL_BIT    = 6;
	localparam int CGC_PM_GAIN_BIT   = 0;
	localparam int CGC_OM_STABLE_BIT = 7;
	localparam int CGC_OM_LSHALT_BIT = 1;
	localparam int CGC_MO_HALT_BIT   = 7;
	localparam int CGC_DIV_W         = 3;

	// divider codes 000..100 are legal
	localparam logic [2:0] CGC_DIV_CODE_MAX = 3'h4;

	// pll multiplication factors
	localparam logic [3:0] CGC_PLL_FACTOR_LO = 4'h8;
	localparam logic [3:0] CGC_PLL_FACTOR_HI = 4'hC;

	// timing
	localparam int CGC_CLK_PERIOD_NS  = 40;
	localparam int CGC_HOLD_TIME_NS   = 5000;
	localparam int CGC_HOLD_CYC       =
		(CGC_HOLD_TIME_NS + CGC_CLK_PERIOD_NS - 1) / CGC_CLK_PERIOD_NS;
	localparam int CGC_MIN_INSTR_CPU_CYC = 2;

	typedef struct packed {
		logic [15:0] addr;
		logic        wr;
		logic        rd;
		logic [7:0]  wdata;
	} cgc_bus_req_s;

	typedef struct packed {
		logic x1_port;
		logic x2_port;
		logic resonator;
		logic ext_clk_in;
	} cgc_pin_mode_s;

	typedef enum logic [1:0] {
		CGC_RUN      = 2'b00,
		CGC_HOLD     = 2'b01,
		CGC_OSC_WAIT = 2'b10
	} cgc_hold_e;

endpackage

//--- testbench/cgc_clock_gen_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module cgc_clock_gen_assertions #(
	parameter int HOLD_CYC = 4
) (
	// clock, reset, bus and status
	input wire logic                  ref_clk,
	input wire logic                  sys_rst,
	input wire cgc_pkg::cgc_bus_req_s bus_req,
	input wire logic                  ls_stop_allowed,
	input wire logic                  stop_mode,
	input wire logic                  cpu_on_resonator,
	input wire logic                  osc_stable_done,
	input wire logic                  timer_h1_ls_sel,
	input wire logic                  pll_multiplier_sel,
	input wire logic                  pll_halt,
	// watched outputs
	input wire logic                  lowspeed_osc_run,
	input wire logic                  wdt_lowspeed_en,
	input wire logic                  timer_h1_lowspeed_en,
	input wire cgc_pkg::cgc_pin_mode_s pin_mode,
	input wire logic                  high_freq_gain,
	input wire logic                  hs_clock_halt,
	input wire logic                  hs_osc_enable,
	input wire logic                  pll_run,
	input wire logic [3:0]            pll_factor,
	input wire logic                  cpu_clk_tick,
	input wire logic                  cpu_clk_hold,
	input wire logic [5:0]            min_instr_ref_cycles
);
	import cgc_pkg::*;
	logic [7:0] hcnt_q;
	wire        ls_wr = bus_req.wr && bus_req.addr == CGC_ADDR_OSC_MODE;
	// length of the current hold run, read when the hold ends
	always_ff @(posedge ref_clk or posedge sys_rst)
		if (sys_rst) hcnt_q <= 8'h00;
		else hcnt_q <= cpu_clk_hold ? hcnt_q + 8'h01 : 8'h00;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	rst_vals_a: assert property (
		$fell(sys_rst) |-> lowspeed_osc_run && !high_freq_gain && hs_clock_halt
		&& pin_mode.x1_port && pin_mode.x2_port && min_instr_ref_cycles == 6'h04)
		else $error("state after reset wrong");
	ls_keep_a: assert property (
		ls_wr && !ls_stop_allowed |=> lowspeed_osc_run)
		else $error("low-speed osc stopped");
	ls_stop_a: assert property (
		ls_wr && ls_stop_allowed |=> lowspeed_osc_run == !$past(bus_req.wdata[1]))
		else $error("low-speed halt bit ignored");
	ls_only_a: assert property (wdt_lowspeed_en == lowspeed_osc_run &&
		timer_h1_lowspeed_en == (lowspeed_osc_run && timer_h1_ls_sel))
		else $error("low-speed clock routed wrong");
	pll_ctl_a: assert property (pll_run == !pll_halt && pll_factor ==
		(pll_multiplier_sel ? CGC_PLL_FACTOR_HI : CGC_PLL_FACTOR_LO))
		else $error("pll control wrong");
	pin_dec_a: assert property ((pin_mode.resonator || pin_mode.ext_clk_in)
		|-> !pin_mode.x2_port && pin_mode.x1_port == pin_mode.ext_clk_in)
		else $error("pin mode decode wrong");
	gain_hold_a: assert property ($rose(high_freq_gain) |-> cpu_clk_hold)
		else $error("no hold on gain set");
	gain_lock_a: assert property (!$fell(high_freq_gain))
		else $error("gain bit changed twice");
	hold_len_a: assert property ($fell(cpu_clk_hold) && !$past(stop_mode)
		&& !cpu_on_resonator |-> hcnt_q >= HOLD_CYC)
		else $error("hold too short");
	res_wait_a: assert property ($fell(cpu_clk_hold) && !$past(stop_mode)
		&& cpu_on_resonator |-> $past(osc_stable_done))
		else $error("hold ended before oscillator settled");
	tick_gate_a: assert property (cpu_clk_hold |-> !cpu_clk_tick)
		else $error("tick during hold");
	min_instr_a: assert property (
		$onehot(min_instr_ref_cycles) && min_instr_ref_cycles >= 6'h02)
		else $error("instruction time wrong");
	hs_osc_a: assert property (
		hs_osc_enable |-> !hs_clock_halt && !stop_mode)
		else $error("oscillator runs while halted");
	stop_exit_a: assert property ($fell(stop_mode) && high_freq_gain
		|-> cpu_clk_hold && !cpu_clk_tick)
		else $error("tick leaked at stop exit");
endmodule // cgc_clock_gen_assertions
bind cgc_clock_gen cgc_clock_gen_assertions #(
	.HOLD_CYC(HOLD_CYC)
) u_chk (
	.ref_clk              (ref_clk),
	.sys_rst              (sys_rst),
	.bus_req              (bus_req),
	.ls_stop_allowed      (ls_stop_allowed),
	.stop_mode            (stop_mode),
	.cpu_on_resonator     (cpu_on_resonator),
	.osc_stable_done      (osc_stable_done),
	.timer_h1_ls_sel      (timer_h1_ls_sel),
	.pll_multiplier_sel   (pll_multiplier_sel),
	.pll_halt             (pll_halt),
	.lowspeed_osc_run     (lowspeed_osc_run),
	.wdt_lowspeed_en      (wdt_lowspeed_en),
	.timer_h1_lowspeed_en (timer_h1_lowspeed_en),
	.pin_mode             (pin_mode),
	.high_freq_gain       (high_freq_gain),
	.hs_clock_halt        (hs_clock_halt),
	.hs_osc_enable        (hs_osc_enable),
	.pll_run              (pll_run),
	.pll_factor           (pll_factor),
	.cpu_clk_tick         (cpu_clk_tick),
	.cpu_clk_hold         (cpu_clk_hold),
	.min_instr_ref_cycles (min_instr_ref_cycles)
);
`default_nettype wire

//--- testbench/cgc_osc_model.sv
`timescale 1ns/1ns
`default_nettype none
module cgc_osc_model #(
	parameter int STAB = 10
) (
	// clock and stop state
	input wire logic ref_clk,
	input wire logic stop_mode,
	// stabilization status
	output logic     osc_stable_done
);
	logic [7:0] cnt_q = 8'h00;
	// the resonator dies in stop, so its settling count restarts there
	always @(posedge ref_clk)
		if (stop_mode) cnt_q <= 8'h00;
		else if (cnt_q < STAB) cnt_q <= cnt_q + 8'h01;
	assign osc_stable_done = cnt_q >= STAB;
endmodule // cgc_osc_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import cgc_pkg::*;
	localparam int HOLD = CGC_HOLD_CYC;
	logic ref_clk = 1'b0, sys_rst = 1'b1, ls_stop_allowed = 1'b0;
	logic hs_int_osc_stable = 1'b1, stop_mode = 1'b0, cpu_on_resonator = 1'b0;
	logic timer_h1_ls_sel = 1'b1, pll_multiplier_sel = 1'b0, pll_halt = 1'b0;
	logic osc_stable_done, lowspeed_osc_run, wdt_lowspeed_en, high_freq_gain;
	logic timer_h1_lowspeed_en, hs_clock_halt, hs_osc_enable, pll_run;
	logic cpu_clk_tick, cpu_clk_hold;
	logic [7:0] bus_rdata;
	logic [3:0] pll_factor;
	logic [5:0] min_instr_ref_cycles;
	cgc_bus_req_s  bus_req = '0;
	cgc_pin_mode_s pin_mode;
	int n_fail = 0, n_tests = 0, n;
	logic [3:0] pins [4] = '{4'hC, 4'h2, 4'hC, 4'h9};

	cgc_clock_gen #(
		.HOLD_CYC(HOLD)
	) u_cgc_clock_gen (
		.ref_clk              (ref_clk),
		.sys_rst              (sys_rst),
		.bus_req              (bus_req),
		.bus_rdata            (bus_rdata),
		.ls_stop_allowed      (ls_stop_allowed),
		.hs_int_osc_stable    (hs_int_osc_stable),
		.stop_mode            (stop_mode),
		.cpu_on_resonator     (cpu_on_resonator),
		.osc_stable_done      (osc_stable_done),
		.timer_h1_ls_sel      (timer_h1_ls_sel),
		.pll_multiplier_sel   (pll_multiplier_sel),
		.pll_halt             (pll_halt),
		.lowspeed_osc_run     (lowspeed_osc_run),
		.wdt_lowspeed_en      (wdt_lowspeed_en),
		.timer_h1_lowspeed_en (timer_h1_lowspeed_en),
		.pin_mode             (pin_mode),
		.high_freq_gain       (high_freq_gain),
		.hs_clock_halt        (hs_clock_halt),
		.hs_osc_enable        (hs_osc_enable),
		.pll_run              (pll_run),
		.pll_factor           (pll_factor),
		.cpu_clk_tick         (cpu_clk_tick),
		.cpu_clk_hold         (cpu_clk_hold),
		.min_instr_ref_cycles (min_instr_ref_cycles)
	);
	cgc_osc_model u_cgc_osc_model (
		.ref_clk         (ref_clk),
		.stop_mode       (stop_mode),
		.osc_stable_done (osc_stable_done)
	);
	always #20 ref_clk = ~ref_clk;

	task automatic chk(input string nm, input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s exp %h got %h", nm, exp, got);
		end
	endtask
	// one idle cycle after each access keeps bus_req single-driven per step
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		bus_req = '{a, 1'b1, 1'b0, d};
		@(negedge ref_clk) bus_req = '0;
		@(negedge ref_clk);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		bus_req = '{a, 1'b0, 1'b1, 8'h00};
		@(negedge ref_clk) bus_req = '0;
		@(negedge ref_clk) chk("rdata", bus_rdata, e);
	endtask
	task automatic t_reset;
		chk("ls_run", lowspeed_osc_run, 1);
		chk("min", {2'h0, min_instr_ref_cycles}, 4);
		rd(CGC_ADDR_PIN_MODE, 8'h00);
		rd(CGC_ADDR_CPU_DIV, 8'h01);
		rd(16'hFF00, 8'h00);
		rd(CGC_ADDR_OSC_MODE, 8'h80);
		rd(CGC_ADDR_MAIN_OSC, 8'h80);
		hs_int_osc_stable = 1'b0;
		rd(CGC_ADDR_OSC_MODE, 8'h00);
	endtask
	task automatic t_div;
		for (int c = 0; c < 5; c++) begin
			wr(CGC_ADDR_CPU_DIV, 8'(c));
			rd(CGC_ADDR_CPU_DIV, 8'(c));
			for (n = 0; n < 40 && cpu_clk_tick !== 1'b1; n++) @(negedge ref_clk);
			@(negedge ref_clk);
			for (n = 1; n < 40 && cpu_clk_tick !== 1'b1; n++) @(negedge ref_clk);
			chk("tick_gap", 8'(n), 8'h01 << c);
			chk("min", {2'h0, min_instr_ref_cycles}, 8'h02 << c);
		end
		wr(CGC_ADDR_CPU_DIV, 8'h05);
		rd(CGC_ADDR_CPU_DIV, 8'h04);
		wr(CGC_ADDR_CPU_DIV, 8'h8A);
		rd(CGC_ADDR_CPU_DIV, 8'h02);
	endtask
	task automatic t_ls;
		wr(CGC_ADDR_OSC_MODE, 8'h02);
		chk("ls_run", lowspeed_osc_run, 1);
		chk("h1_en", timer_h1_lowspeed_en, 1);
		ls_stop_allowed = 1'b1;
		wr(CGC_ADDR_OSC_MODE, 8'h02);
		chk("ls_run", lowspeed_osc_run, 0);
		chk("wdt_en", wdt_lowspeed_en, 0);
		wr(CGC_ADDR_OSC_MODE, 8'h00);
		chk("ls_run", lowspeed_osc_run, 1);
		timer_h1_ls_sel = 1'b0;
		@(negedge ref_clk) chk("h1_en", timer_h1_lowspeed_en, 0);
	endtask
	task automatic t_pin;
		for (int i = 0; i < 4; i++) begin
			wr(CGC_ADDR_PIN_MODE, 8'(i << 6));
			chk("pins", {4'h0, pin_mode}, {4'h0, pins[i]});
		end
		wr(CGC_ADDR_MAIN_OSC, 8'h00);
		chk("hs_en", hs_osc_enable, 1);
		wr(CGC_ADDR_PIN_MODE, 8'h00);
		rd(CGC_ADDR_PIN_MODE, 8'hC0);
		wr(CGC_ADDR_MAIN_OSC, 8'h80);
		chk("hs_en", hs_osc_enable, 0);
		for (int i = 0; i < 2; i++) begin
			pll_multiplier_sel = i[0];
			pll_halt = i[0];
			@(negedge ref_clk);
			chk("pll", {3'h0, pll_run, pll_factor}, i ? 8'h0C : 8'h18);
		end
	endtask
	task automatic t_gain;
		wr(CGC_ADDR_PIN_MODE, 8'hC1);
		for (n = 1; n < 200 && cpu_clk_hold === 1'b1; n++) @(negedge ref_clk);
		chk("hold", 8'(n), HOLD);
		rd(CGC_ADDR_PIN_MODE, 8'hC1);
		wr(CGC_ADDR_PIN_MODE, 8'hC0);
		rd(CGC_ADDR_PIN_MODE, 8'hC1);
	endtask
	task automatic t_stop;
		for (int r = 0; r < 2; r++) begin
			cpu_on_resonator = r[0];
			stop_mode = 1'b1;
			repeat (3) @(negedge ref_clk);
			chk("stop_hold", cpu_clk_hold, 1);
			stop_mode = 1'b0;
			@(negedge ref_clk);
			for (n = 0; n < 200 && cpu_clk_hold === 1'b1; n++) @(negedge ref_clk);
			chk("exit_hold", 8'(r ? n >= 10 : n == HOLD), 1);
		end
	endtask
	task automatic summarize;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (12) @(negedge ref_clk);
		sys_rst = 1'b0;
		t_reset();
		t_div();
		t_ls();
		t_pin();
		t_gain();
		t_stop();
		summarize();
	end
	initial begin
		#400000;
		n_fail++;
		summarize();
	end
endmodule // tb
`default_nettype wire
